// ===== taa_defines.svh
// Register offsets, field positions, reset values and timing figures.
`ifndef TAA_DEFINES_SVH
`define TAA_DEFINES_SVH
`define TAA_OFF_CTRL       8'h00
`define TAA_OFF_TIMEOUT    8'h04
`define TAA_OFF_PROFILE    8'h08
`define TAA_OFF_STATUS     8'h0C
`define TAA_OFF_IRQ_STAT   8'h10
`define TAA_OFF_IRQ_MASK   8'h14
`define TAA_OFF_NAME_LO    8'h18
`define TAA_OFF_NAME_HI    8'h1C
`define TAA_CTRL_ANNOUNCE  0
`define TAA_CTRL_PROGRAM   1
`define TAA_CTRL_LINKING   2
`define TAA_TMO_RISE_BIT   7
`define TAA_EV_START       0
`define TAA_EV_END         1
`define TAA_EV_EXPIRE      2
`define TAA_EV_NAME        3
`define TAA_EV_W           4
`define TAA_TIMEOUT_RST    8'h00
`define TAA_PROFILE_RST    3'h0
`define TAA_NAME_SYNC_MS   400
`define TAA_CLK_KHZ        10000
`define TAA_NAME_SYNC_CYC  (`TAA_NAME_SYNC_MS * `TAA_CLK_KHZ)
`endif

// ===== taa_pkg.sv
// Types shared by the traffic announcement control block.
package taa_pkg;
  typedef enum logic [0:0] {
    TAA_NAME_IDLE,
    TAA_NAME_SYNC
  } taa_name_st_t;
  typedef enum logic [0:0] {
    TAA_SRC_SWITCH,
    TAA_SRC_COMMAND
  } taa_src_t;
endpackage

// ===== taa_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module taa_sync #(
  parameter int W        = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== taa_top.sv
// Traffic announcement flag control with APB registers.
// ------------------------------------------------------------------
// Notes on behaviour
// - Announcement held by the switch ignores operator flag writes.
// - Announcement set by operator ignores the switch input.
// - Changing the active profile clears the announcement flag.
// - Timeout zero: switch is level sensitive, low gives flag one.
// - Timeout 1..127: falling edge sets flag, cleared after the minutes.
// - Adding 128 also lets a rising edge clear the flag before expiry.
// - Timeout expiry happens only on real time clock minute ticks.
// - Other network flag ignores timeout; its switch is level only.
// - Program flag zero forces the effective timeout to zero.
// - Device drives program and announcement flags to stay consistent.
// - Eight character name text; an all empty text disables it.
// - Name text update takes up to 400 ms to resynchronise.
// ------------------------------------------------------------------
`timescale 1ns/1ps
`include "taa_defines.svh"
module taa_top
  import taa_pkg::*;
#(
  parameter int unsigned NAME_SYNC_CYC = `TAA_NAME_SYNC_CYC,
  parameter int          PROFILE_W     = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        announce_switch_n,
  input  wire logic        other_net_switch_n,
  input  wire logic        minute_tick,
  output logic             traffic_announce_flag,
  output logic             traffic_program_flag,
  output logic             other_net_announce_flag,
  output logic [63:0]      traffic_name_text,
  output logic             name_enable,
  output logic             name_busy,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic       sw_prev_q;
  logic       sw_fall;
  logic       sw_rise;

  taa_sync #(
    .W   (2),
    .RST (2'b11)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({other_net_switch_n, announce_switch_n}),
    .q       (pins_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_prev_q <= 1'b1;
    end else begin
      sw_prev_q <= pins_s[0];
    end
  end

  assign sw_fall = sw_prev_q & ~pins_s[0];
  assign sw_rise = ~sw_prev_q & pins_s[0];

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic        pready_q;
  logic        access;
  logic        wr;
  logic        rd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `TAA_OFF_NAME_HI);
  endfunction

  assign access = psel & penable & pready_q;
  assign wr     = access & pwrite & mapped(paddr);
  assign rd     = access & ~pwrite;

  // One wait state keeps pready coming straight from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic                 program_q;
  logic                 linking_q;
  logic [7:0]           timeout_q;
  logic [PROFILE_W-1:0] profile_q;
  logic                 profile_chg;
  logic [7:0]           eff_timeout;
  logic                 edge_mode;

  assign profile_chg = wr && hit(paddr, `TAA_OFF_PROFILE)
                       && (pwdata[PROFILE_W-1:0] != profile_q);
  assign eff_timeout = program_q ? timeout_q : 8'h00;
  assign edge_mode   = (eff_timeout[6:0] != 7'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_q <= 1'b0;
      linking_q <= 1'b0;
      timeout_q <= `TAA_TIMEOUT_RST;
      profile_q <= `TAA_PROFILE_RST;
    end else if (wr) begin
      if (hit(paddr, `TAA_OFF_CTRL)) begin
        program_q <= pwdata[`TAA_CTRL_PROGRAM];
        linking_q <= pwdata[`TAA_CTRL_LINKING];
      end
      if (hit(paddr, `TAA_OFF_TIMEOUT)) begin
        timeout_q <= pwdata[7:0];
      end
      if (hit(paddr, `TAA_OFF_PROFILE)) begin
        profile_q <= pwdata[PROFILE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Announcement flag sources and minute timeout
  // ----------------------------------------------------------------
  logic       sw_act_q;
  logic       cmd_act_q;
  logic [6:0] min_left_q;
  logic       cmd_wr;
  logic       expire;
  logic       active;

  assign cmd_wr = wr && hit(paddr, `TAA_OFF_CTRL);
  assign active = sw_act_q | cmd_act_q;
  assign expire = edge_mode & sw_act_q & minute_tick
                  & (min_left_q == 7'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_act_q <= 1'b0;
    end else if (profile_chg) begin
      cmd_act_q <= 1'b0;
    end else if (cmd_wr && !sw_act_q) begin
      cmd_act_q <= pwdata[`TAA_CTRL_ANNOUNCE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_act_q <= 1'b0;
    end else if (profile_chg) begin
      sw_act_q <= 1'b0;
    end else if (cmd_act_q) begin
      sw_act_q <= 1'b0;
    end else if (!edge_mode) begin
      sw_act_q <= ~pins_s[0];
    end else if (sw_fall) begin
      sw_act_q <= 1'b1;
    end else if (sw_rise && eff_timeout[`TAA_TMO_RISE_BIT]) begin
      sw_act_q <= 1'b0;
    end else if (expire) begin
      sw_act_q <= 1'b0;
    end
  end

  // The count only moves on minute ticks, so a partial first minute is
  // accepted: expiry lands on a whole minute boundary.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_left_q <= 7'd0;
    end else if (edge_mode && !cmd_act_q && sw_fall) begin
      min_left_q <= eff_timeout[6:0];
    end else if (minute_tick && sw_act_q && min_left_q != 7'd0) begin
      min_left_q <= min_left_q - 7'd1;
    end
  end

  // ----------------------------------------------------------------
  // Transmitted flags
  // ----------------------------------------------------------------
  logic ann_q;
  logic tp_q;
  logic on_q;
  logic ann_d;
  logic on_d;

  // Other network flag follows its switch level only, untouched by timeout.
  assign on_d  = linking_q & ~pins_s[1];
  // An announcement is only sent with the program flag set.
  assign ann_d = active & program_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ann_q <= 1'b0;
      tp_q  <= 1'b0;
      on_q  <= 1'b0;
    end else begin
      ann_q <= ann_d;
      tp_q  <= program_q | on_d;
      on_q  <= on_d;
    end
  end

  assign traffic_announce_flag   = ann_q;
  assign traffic_program_flag    = tp_q;
  assign other_net_announce_flag = on_q;

  // ----------------------------------------------------------------
  // Traffic name text with group order resynchronisation
  // ----------------------------------------------------------------
  logic [63:0]  shadow_q;
  logic [63:0]  text_q;
  logic         name_en_q;
  logic [31:0]  sync_cnt_q;
  taa_name_st_t name_st_q;
  logic         name_done;

  // A commit in the finishing cycle wins, so the text never moves while busy.
  assign name_done = (name_st_q == TAA_NAME_SYNC) && (sync_cnt_q == 32'd0)
                     && !(wr && hit(paddr, `TAA_OFF_NAME_HI));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= 64'h0000_0000_0000_0000;
    end else if (wr && hit(paddr, `TAA_OFF_NAME_LO)) begin
      shadow_q[31:0] <= pwdata;
    end else if (wr && hit(paddr, `TAA_OFF_NAME_HI)) begin
      shadow_q[63:32] <= pwdata;
    end
  end

  // Writing the high word commits the text; a new commit restarts the wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      name_st_q  <= TAA_NAME_IDLE;
      sync_cnt_q <= 32'd0;
    end else if (wr && hit(paddr, `TAA_OFF_NAME_HI)) begin
      name_st_q  <= TAA_NAME_SYNC;
      sync_cnt_q <= NAME_SYNC_CYC - 1;
    end else begin
      unique case (name_st_q)
        TAA_NAME_IDLE: begin
          sync_cnt_q <= 32'd0;
        end
        TAA_NAME_SYNC: begin
          if (sync_cnt_q == 32'd0) begin
            name_st_q <= TAA_NAME_IDLE;
          end else begin
            sync_cnt_q <= sync_cnt_q - 32'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      text_q    <= 64'h0000_0000_0000_0000;
      name_en_q <= 1'b0;
    end else if (name_done) begin
      text_q    <= shadow_q;
      name_en_q <= (shadow_q != 64'h0000_0000_0000_0000);
    end
  end

  assign traffic_name_text = text_q;
  assign name_enable       = name_en_q;
  assign name_busy         = (name_st_q == TAA_NAME_SYNC);

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [`TAA_EV_W-1:0] ev;
  logic [`TAA_EV_W-1:0] ist_q;
  logic [`TAA_EV_W-1:0] imask_q;
  logic [`TAA_EV_W-1:0] clr;
  logic                 irq_q;
  logic                 ann_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ann_prev_q <= 1'b0;
    end else begin
      ann_prev_q <= ann_q;
    end
  end

  always_comb begin
    ev                  = '0;
    ev[`TAA_EV_START]   = ann_q & ~ann_prev_q;
    ev[`TAA_EV_END]     = ~ann_q & ann_prev_q;
    ev[`TAA_EV_EXPIRE]  = expire;
    ev[`TAA_EV_NAME]    = name_done;
  end

  assign clr = (wr && hit(paddr, `TAA_OFF_IRQ_STAT))
               ? pwdata[`TAA_EV_W-1:0] : '0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      if (wr && hit(paddr, `TAA_OFF_IRQ_MASK)) begin
        imask_q <= pwdata[`TAA_EV_W-1:0];
      end
      irq_q <= |(((ist_q & ~clr) | ev) & imask_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic        err_q;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `TAA_OFF_CTRL: begin
        rd_mux[`TAA_CTRL_ANNOUNCE] = cmd_act_q;
        rd_mux[`TAA_CTRL_PROGRAM]  = program_q;
        rd_mux[`TAA_CTRL_LINKING]  = linking_q;
      end
      `TAA_OFF_TIMEOUT:  rd_mux[7:0] = timeout_q;
      `TAA_OFF_PROFILE:  rd_mux[PROFILE_W-1:0] = profile_q;
      `TAA_OFF_STATUS: begin
        rd_mux[0]    = ann_q;
        rd_mux[1]    = sw_act_q;
        rd_mux[2]    = cmd_act_q;
        rd_mux[3]    = on_q;
        rd_mux[4]    = tp_q;
        rd_mux[5]    = name_busy;
        rd_mux[6]    = name_en_q;
        rd_mux[7]    = pins_s[0];
        rd_mux[14:8] = min_left_q;
        rd_mux[23:16] = eff_timeout;
      end
      `TAA_OFF_IRQ_STAT: rd_mux[`TAA_EV_W-1:0] = ist_q;
      `TAA_OFF_IRQ_MASK: rd_mux[`TAA_EV_W-1:0] = imask_q;
      `TAA_OFF_NAME_LO:  rd_mux = shadow_q[31:0];
      `TAA_OFF_NAME_HI:  rd_mux = shadow_q[63:32];
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q   <= ~mapped(paddr);
    end else begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = pready_q;
  assign pslverr = err_q;

  logic unused_rd;
  assign unused_rd = rd;

endmodule

// ===== taa_top_sva.sv
// Port assertions for the traffic announcement control block.
`timescale 1ns/1ps
module taa_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        other_net_switch_n,
  input wire logic        traffic_announce_flag,
  input wire logic        traffic_program_flag,
  input wire logic        other_net_announce_flag,
  input wire logic [63:0] traffic_name_text,
  input wire logic        name_enable,
  input wire logic        name_busy,
  input wire logic        irq
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  one_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ----------------------------------------------------------------
  // Flags and name text
  // ----------------------------------------------------------------
  name_busy_a: assert property (psel && penable && pready && pwrite
    && paddr == 8'h1C |=> name_busy)
    else $error("name commit did not start the wait");
  name_hold_a: assert property (name_busy |-> $stable(traffic_name_text))
    else $error("name text moved while busy");
  name_enable_a: assert property (name_enable == (traffic_name_text != 0))
    else $error("name enable disagrees with text");
  announce_prog_a: assert property (traffic_announce_flag |-> traffic_program_flag)
    else $error("announcement without program flag");
  other_level_a: assert property (other_net_announce_flag
    |-> !$past(other_net_switch_n, 3))
    else $error("other network flag without low pin");
  name_commit_c: cover property ($fell(name_busy));
  irq_c: cover property ($rose(irq));
  announce_c: cover property ($fell(traffic_announce_flag));
endmodule

bind taa_top taa_top_sva i_taa_top_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .other_net_switch_n(other_net_switch_n),
  .traffic_announce_flag(traffic_announce_flag),
  .traffic_program_flag(traffic_program_flag),
  .other_net_announce_flag(other_net_announce_flag),
  .traffic_name_text(traffic_name_text), .name_enable(name_enable),
  .name_busy(name_busy), .irq(irq));

// ===== taa_ext_model.sv
// Model of the external switches and the real time clock minute source.
`timescale 1ns/1ps
module taa_ext_model #(
  parameter int MIN_CYC = 40
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ta_on,
  input  wire logic on_on,
  input  wire logic plugged,
  output logic      announce_switch_n,
  output logic      other_net_switch_n,
  output logic      minute_tick
);
  int cnt_q;
  // The announce pin has a pull-up, so an unplugged switch reads high.
  assign announce_switch_n  = plugged ? !ta_on : 1'h1;
  assign other_net_switch_n = !on_on;
  // The clock runs free, so the first minute of a timeout is partial.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= 0;
      minute_tick <= 1'h0;
    end else begin
      minute_tick <= (cnt_q == MIN_CYC - 1);
      cnt_q       <= (cnt_q == MIN_CYC - 1) ? 0 : cnt_q + 1;
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking testbench of the traffic announcement control block.
`timescale 1ns/1ps
`include "taa_defines.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sw_n, on_n, tick, ta, tp, on_f, nen, nbusy, irq, err;
  logic        ta_on, on_on, plugged;
  logic [63:0] text;
  int          n_errors, comparisons, ticks, last_tick, cyc, t0, n;

  always #50 pclk = ~pclk;
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    if (tick === 1'h1) begin
      ticks     <= ticks + 1;
      last_tick <= cyc;
    end
  end

  taa_top #(.NAME_SYNC_CYC(20)) i_taa_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .announce_switch_n(sw_n), .other_net_switch_n(on_n),
    .minute_tick(tick), .traffic_announce_flag(ta),
    .traffic_program_flag(tp), .other_net_announce_flag(on_f),
    .traffic_name_text(text), .name_enable(nen), .name_busy(nbusy),
    .irq(irq));
  taa_ext_model #(.MIN_CYC(40)) i_taa_ext_model (.pclk(pclk),
    .presetn(presetn), .ta_on(ta_on), .on_on(on_on), .plugged(plugged),
    .announce_switch_n(sw_n), .other_net_switch_n(on_n),
    .minute_tick(tick));

  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // The answer is taken at the rising edge at which pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      n_errors++;
      end_of_test;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask

  // Pin effects need up to five edges (irq), so six cycles leave them settled.
  task sw(input logic a, input logic b, input logic p);
    @(posedge pclk);
    ta_on   <= a;
    on_on   <= b;
    plugged <= p;
    repeat (6) @(negedge pclk);
  endtask

  task wait_ta_low;
    int i;
    for (i = 0; i < 200 && ta !== 1'h0; i++)
      @(negedge pclk);
    if (i >= 200) begin
      n_errors++;
      end_of_test;
    end
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, ta_on, on_on, plugged} = 8'h00;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    {n_errors, comparisons, ticks, last_tick, cyc} = 160'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rdc(`TAA_OFF_TIMEOUT, 32'h0000_00FF, 32'(`TAA_TIMEOUT_RST));
    rdc(`TAA_OFF_PROFILE, 32'h0000_0007, 32'(`TAA_PROFILE_RST));
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    chkb(err, 1'h1);
    wr(`TAA_OFF_CTRL, 32'h0000_0002);
    sw(1'h1, 1'h0, 1'h1);
    chkb(ta, 1'h1);
    wr(`TAA_OFF_CTRL, 32'h0000_0003);
    chkb(ta, 1'h1);
    rdc(`TAA_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
    sw(1'h0, 1'h0, 1'h0);
    chkb(ta, 1'h0);
    wr(`TAA_OFF_CTRL, 32'h0000_0003);
    sw(1'h1, 1'h0, 1'h1);
    rdc(`TAA_OFF_STATUS, 32'h0000_0002, 32'h0000_0000);
    sw(1'h0, 1'h0, 1'h1);
    chkb(ta, 1'h1);
    wr(`TAA_OFF_PROFILE, 32'h0000_0001);
    repeat (3) @(negedge pclk);
    chkb(ta, 1'h0);
    wr(`TAA_OFF_TIMEOUT, 32'h0000_0002);
    wr(`TAA_OFF_CTRL, 32'h0000_0000);
    rdc(`TAA_OFF_STATUS, 32'h00FF_0000, 32'h0000_0000);
    wr(`TAA_OFF_CTRL, 32'h0000_0002);
    rdc(`TAA_OFF_STATUS, 32'h00FF_0000, 32'h0002_0000);
    wr(`TAA_OFF_IRQ_STAT, 32'h0000_000F);
    wr(`TAA_OFF_IRQ_MASK, 32'h0000_000F);
    rdc(`TAA_OFF_IRQ_STAT, 32'h0000_000F, 32'h0000_0000);
    chkb(irq, 1'h0);
    t0 = ticks;
    sw(1'h1, 1'h0, 1'h1);
    chkb(ta, 1'h1);
    chkb(irq, 1'h1);
    sw(1'h0, 1'h0, 1'h1);
    chkb(ta, 1'h1);
    wait_ta_low;
    chk(32'(ticks - t0), 32'h0000_0002);
    chkb(cyc - last_tick <= 4, 1'h1);
    rdc(`TAA_OFF_IRQ_STAT, 32'h0000_0005, 32'h0000_0005);
    wr(`TAA_OFF_IRQ_STAT, 32'h0000_000F);
    rdc(`TAA_OFF_IRQ_STAT, 32'h0000_000F, 32'h0000_0000);
    chkb(irq, 1'h0);
    wr(`TAA_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`TAA_OFF_TIMEOUT, 32'h0000_0082);
    sw(1'h1, 1'h0, 1'h1);
    chkb(irq, 1'h0);
    chkb(ta, 1'h1);
    sw(1'h0, 1'h0, 1'h1);
    chkb(ta, 1'h0);
    wr(`TAA_OFF_CTRL, 32'h0000_0004);
    sw(1'h0, 1'h1, 1'h1);
    chkb(on_f, 1'h1);
    chkb(tp, 1'h1);
    sw(1'h0, 1'h0, 1'h1);
    chkb(on_f, 1'h0);
    chkb(tp, 1'h0);
    wr(`TAA_OFF_NAME_LO, 32'h4646_4152);
    wr(`TAA_OFF_NAME_HI, 32'h2043_4946);
    n = 0;
    repeat (60) begin
      @(negedge pclk);
      if (nbusy === 1'h1)
        n++;
    end
    chk(32'(n), 32'h0000_0014);
    chk(text[63:32], 32'h2043_4946);
    chk(text[31:0], 32'h4646_4152);
    chkb(nen, 1'h1);
    wr(`TAA_OFF_NAME_LO, 32'h0000_0000);
    wr(`TAA_OFF_NAME_HI, 32'h0000_0000);
    repeat (30) @(negedge pclk);
    chkb(nen, 1'h0);
    end_of_test;
  end
endmodule
